/* File: verilog/tcpsm_defines.svh */
`ifndef TCPSM_DEFINES_SVH
`define TCPSM_DEFINES_SVH

// Clock rate in kHz (250 MHz)
`define TCPSM_CLK_KHZ 250000
// Active refresh floor, in ms
`define TCPSM_ACTIVE_REFRESH_MS 20
`define TCPSM_ACTIVE_REFRESH_CYC (`TCPSM_ACTIVE_REFRESH_MS * `TCPSM_CLK_KHZ)
// Faulty-input pulse width, in ms
`define TCPSM_FAULT_PULSE_MS 50
`define TCPSM_FAULT_PULSE_CYC (`TCPSM_FAULT_PULSE_MS * `TCPSM_CLK_KHZ)
// Slow refresh interval step, in ms
`define TCPSM_SLOW_STEP_MS 20
`define TCPSM_SLOW_STEP_CYC (`TCPSM_SLOW_STEP_MS * `TCPSM_CLK_KHZ)
// One second in cycles
`define TCPSM_SECOND_CYC (1000 * `TCPSM_CLK_KHZ)
// Sensor auto-reset choices, in seconds
`define TCPSM_AUTORST_SHORT_S 5
`define TCPSM_AUTORST_LONG_S 20
// Default general output level
`define TCPSM_GPO_DEFAULT 1'b0

`endif

/* File: verilog/tcpsm_pkg.sv */
package tcpsm_pkg;
  typedef enum logic [2:0] {
    StBoot,
    StActive,
    StLookTouch,
    StLookProx,
    StDeepSleep,
    StConfig
  } tcpsm_state_e;

  typedef struct packed {
    logic wakeOnApproach;
    logic proxToggle;
    logic autoResetLong;
    logic [7:0] stateTimeoutSec;
    logic [7:0] slowRefreshSteps;
  } tcpsm_cfg_s;

  typedef struct packed {
    logic scanRun;
    logic scanAll;
    logic scanProxOnly;
    logic lowPower;
    logic outEnable;
    logic hostIrqEnable;
    logic gpoEnable;
    logic nackAddr;
  } tcpsm_ctl_s;
endpackage

/* File: verilog/tcpsm_pulse.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcpsm_defines.svh"

module tcpsm_pulse #(
  parameter int unsigned PULSE_CYC = `TCPSM_FAULT_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic pulse
);
  logic [31:0] count_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= 32'h0;
    end else if (start) begin
      count_q <= PULSE_CYC;
    end else if (count_q != 32'h0) begin
      count_q <= count_q - 32'h1;
    end
  end

  assign pulse = (count_q != 32'h0);
endmodule
`default_nettype wire

/* File: verilog/tcpsm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcpsm_defines.svh"

// How it works
// RULE1: Boot restores stored configuration, then runs diagnostics before any scanning.
// RULE2: Active scans periodically, drives outputs and host interrupt; refresh >= 20 ms.
// RULE3: Look-for-Touch scans all sensors at slow interval, keeps general outputs.
// RULE4: Look-for-Proximity scans only wake-enabled proximity sensors, drives nothing.
// RULE5: Deep Sleep: no scanning, general outputs return to default.
// RULE6: Configuration: no scanning or reporting; idle until reset.
// RULE7: Host commands enter and leave Deep Sleep; other moves are automatic.
// RULE8: Host configuration change moves the device to Configuration.
// RULE9: Corrupted configuration at end of Boot moves to Configuration.
// RULE10: Look-for-Proximity only with wake-on-approach on and proximity toggle off.
// RULE11: Proximity presence in Look-for-Proximity moves to Look-for-Touch.
// RULE12: Touch in Look-for-Touch moves to Active; Active holds while touched.
// RULE13: Active drops to Look-for-Touch only with no touch and buzzer idle.
// RULE14: No proximity in Look-for-Touch moves to Look-for-Proximity when allowed.
// RULE15: Timeout in seconds sets minimum touch-free time before each drop.
// RULE16: Slow interval sets minimum spacing between scan starts in slow states.
// RULE17: Low-power phase follows each interval's scans in the three scanning states.
// RULE18: Low-power phase skipped on bus activity or clock line held low.
// RULE19: Host should leave the bus idle and pulled up when not talking.
// RULE20: Sensor auto-reset interval selectable as 5 or 20 seconds.
// RULE21: A diagnostics failure gives a 50 ms pulse on that input's output.
// RULE22: Power, pin or software reset all behave alike and enter Boot.
// RULE23: Address matches get NACK while waking until Active is reached.
// RULE24: Boot with valid configuration proceeds to Active and normal scanning.
module tcpsm_top #(
  parameter int unsigned NUM_SENSE = 8,
  parameter int unsigned ACTIVE_REFRESH_CYC = `TCPSM_ACTIVE_REFRESH_CYC,
  parameter int unsigned FAULT_PULSE_CYC = `TCPSM_FAULT_PULSE_CYC,
  parameter int unsigned SLOW_STEP_CYC = `TCPSM_SLOW_STEP_CYC,
  parameter int unsigned SECOND_CYC = `TCPSM_SECOND_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic softwareResetCommand,
  input wire tcpsm_pkg::tcpsm_cfg_s cfgIn,
  input wire logic restoreDone,
  input wire logic cfgCorrupt,
  input wire logic diagDone,
  input wire logic [NUM_SENSE-1:0] diagFail,
  input wire logic scanDone,
  input wire logic touchSeen,
  input wire logic proxSeen,
  input wire logic buzzerBusy,
  input wire logic hostSleepCmd,
  input wire logic hostWakeCmd,
  input wire logic hostCfgWrite,
  input wire logic busActivity,
  input wire logic sclLow,
  input wire logic addrMatch,
  output tcpsm_pkg::tcpsm_state_e state,
  output tcpsm_pkg::tcpsm_ctl_s ctl,
  output logic restoreStart,
  output logic diagStart,
  output logic scanStart,
  output logic gpoReset,
  output logic [NUM_SENSE-1:0] faultPulse,
  output logic sensorAutoReset,
  output logic [31:0] autoResetSec
);
  tcpsm_pkg::tcpsm_state_e state_q, state_d;
  tcpsm_pkg::tcpsm_cfg_s cfg_q;
  logic bootPhase_q;
  logic [31:0] refresh_q;
  logic [31:0] secTick_q;
  logic [7:0] idleSec_q;
  logic scanBusy_q;
  logic lowPower_q;
  logic waking_q;
  logic [31:0] autoCnt_q;
  logic [31:0] autoSec_q;
  logic anyReset;
  logic proxAllowed;
  logic timedOut;
  logic intervalDone;
  logic [31:0] intervalCyc;
  logic [NUM_SENSE-1:0] pulseRaw;
  logic [NUM_SENSE-1:0] faultPulse_q;
  logic startScan;

  assign anyReset = rst | softwareResetCommand; // RULE22
  assign proxAllowed = cfg_q.wakeOnApproach & ~cfg_q.proxToggle; // RULE10
  assign timedOut = (idleSec_q >= cfg_q.stateTimeoutSec); // RULE15
  // Slow interval never shorter than one step so a zero setting cannot spin
  assign intervalCyc = (state_q == tcpsm_pkg::StActive) ? ACTIVE_REFRESH_CYC :
    (SLOW_STEP_CYC * ((cfg_q.slowRefreshSteps == 8'h0) ? 32'h1 :
    {24'h0, cfg_q.slowRefreshSteps})); // RULE2 RULE16
  assign intervalDone = (refresh_q >= intervalCyc - 32'h1);

  // Configuration latched only when the Boot restore completes, so new settings need a reset
  always_ff @(posedge clk) begin
    if (anyReset) begin
      cfg_q <= '0;
    end else if (state_q == tcpsm_pkg::StBoot && bootPhase_q == 1'b0 && restoreDone) begin
      cfg_q <= cfgIn; // RULE1 RULE6
    end
  end

  // Boot: phase 0 restores, phase 1 runs diagnostics
  always_ff @(posedge clk) begin
    if (anyReset) begin
      bootPhase_q <= 1'b0;
    end else if (state_q == tcpsm_pkg::StBoot && restoreDone) begin
      bootPhase_q <= 1'b1; // RULE1
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      tcpsm_pkg::StBoot: begin
        if (bootPhase_q && diagDone) begin
          state_d = cfgCorrupt ? tcpsm_pkg::StConfig : tcpsm_pkg::StActive; // RULE9 RULE24
        end
      end
      tcpsm_pkg::StActive: begin
        if (!touchSeen && !buzzerBusy && timedOut) begin
          state_d = tcpsm_pkg::StLookTouch; // RULE13 RULE15
        end
      end
      tcpsm_pkg::StLookTouch: begin
        if (touchSeen) begin
          state_d = tcpsm_pkg::StActive; // RULE12
        end else if (!proxSeen && proxAllowed && timedOut) begin
          state_d = tcpsm_pkg::StLookProx; // RULE14
        end
      end
      tcpsm_pkg::StLookProx: begin
        if (proxSeen) begin
          state_d = tcpsm_pkg::StLookTouch; // RULE11
        end
      end
      tcpsm_pkg::StDeepSleep: begin
        if (hostWakeCmd) begin
          state_d = tcpsm_pkg::StActive; // RULE7
        end
      end
      tcpsm_pkg::StConfig: begin
        state_d = tcpsm_pkg::StConfig; // RULE6
      end
      default: begin
        state_d = tcpsm_pkg::StBoot;
      end
    endcase
    // Host commands outrank automatic moves; configuration write outranks sleep
    if (state_q != tcpsm_pkg::StBoot && state_q != tcpsm_pkg::StConfig) begin
      if (hostCfgWrite) begin
        state_d = tcpsm_pkg::StConfig; // RULE8
      end else if (hostSleepCmd && state_q != tcpsm_pkg::StDeepSleep) begin
        state_d = tcpsm_pkg::StDeepSleep; // RULE7
      end
    end
  end

  always_ff @(posedge clk) begin
    if (anyReset) begin
      state_q <= tcpsm_pkg::StBoot; // RULE22
    end else begin
      state_q <= state_d;
    end
  end

  // Refresh interval counter; restarts on any state change
  always_ff @(posedge clk) begin
    if (anyReset || state_d != state_q || intervalDone) begin
      refresh_q <= 32'h0;
    end else if (refresh_q == 32'h0 && scanBusy_q) begin
      // Overrunning scan holds the interval open, so refresh is the larger
      refresh_q <= 32'h0; // RULE2
    end else begin
      refresh_q <= refresh_q + 32'h1;
    end
  end

  assign startScan = (state_q == tcpsm_pkg::StActive || state_q == tcpsm_pkg::StLookTouch ||
    state_q == tcpsm_pkg::StLookProx) && state_d == state_q && refresh_q == 32'h0
    && !scanBusy_q; // RULE16

  // A scan overrunning the interval stretches it, so refresh is the larger
  always_ff @(posedge clk) begin
    if (anyReset || state_d != state_q) begin
      scanBusy_q <= 1'b0;
    end else if (startScan) begin
      scanBusy_q <= 1'b1;
    end else if (scanDone) begin
      scanBusy_q <= 1'b0; // RULE2
    end
  end

  // Low-power phase between end of scan and next interval
  always_ff @(posedge clk) begin
    if (anyReset) begin
      lowPower_q <= 1'b0;
    end else if (state_d != state_q || startScan || busActivity || sclLow) begin
      lowPower_q <= 1'b0; // RULE18
    end else if (scanBusy_q && scanDone) begin
      lowPower_q <= 1'b1; // RULE17
    end
  end

  // Touch-free seconds in the current state
  always_ff @(posedge clk) begin
    if (anyReset || state_d != state_q || touchSeen ||
        (state_q == tcpsm_pkg::StLookTouch && proxSeen)) begin
      secTick_q <= 32'h0;
      idleSec_q <= 8'h0;
    end else if (secTick_q >= SECOND_CYC - 32'h1) begin
      secTick_q <= 32'h0;
      if (idleSec_q != 8'hff) begin
        idleSec_q <= idleSec_q + 8'h1; // RULE15
      end
    end else begin
      secTick_q <= secTick_q + 32'h1;
    end
  end

  // NACK from wake-up until Active is reached
  always_ff @(posedge clk) begin
    if (anyReset) begin
      waking_q <= 1'b1;
    end else if (state_q == tcpsm_pkg::StActive) begin
      waking_q <= 1'b0; // RULE23
    end else if (addrMatch && (lowPower_q || state_q == tcpsm_pkg::StDeepSleep)) begin
      waking_q <= 1'b1; // RULE23
    end
  end

  // Sensor auto-reset tick, 5 or 20 seconds
  always_ff @(posedge clk) begin
    if (anyReset || touchSeen == 1'b0) begin
      autoCnt_q <= 32'h0;
      autoSec_q <= 32'h0;
      sensorAutoReset <= 1'b0;
    end else if (autoCnt_q >= SECOND_CYC - 32'h1) begin
      autoCnt_q <= 32'h0;
      if (autoSec_q + 32'h1 >= autoResetSec) begin
        autoSec_q <= 32'h0;
        sensorAutoReset <= 1'b1; // RULE20
      end else begin
        autoSec_q <= autoSec_q + 32'h1;
        sensorAutoReset <= 1'b0;
      end
    end else begin
      autoCnt_q <= autoCnt_q + 32'h1;
      sensorAutoReset <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (anyReset) begin
      autoResetSec <= 32'(`TCPSM_AUTORST_SHORT_S);
    end else begin
      autoResetSec <= cfg_q.autoResetLong ? 32'(`TCPSM_AUTORST_LONG_S) :
        32'(`TCPSM_AUTORST_SHORT_S); // RULE20
    end
  end

  // One pulse timer per sense input
  for (genvar i = 0; i < NUM_SENSE; i++) begin : g_fault
    tcpsm_pulse #(
      .PULSE_CYC(FAULT_PULSE_CYC)
    ) u_pulse (
      .clk(clk),
      .rst(anyReset),
      .start(state_q == tcpsm_pkg::StBoot && bootPhase_q && diagDone && diagFail[i]),
      .pulse(pulseRaw[i])
    ); // RULE21
  end

  always_ff @(posedge clk) begin
    if (anyReset) begin
      faultPulse_q <= '0;
    end else begin
      faultPulse_q <= pulseRaw; // RULE21
    end
  end
  assign faultPulse = faultPulse_q;

  // Registered outputs
  always_ff @(posedge clk) begin
    if (anyReset) begin
      state <= tcpsm_pkg::StBoot;
      ctl <= '0;
      restoreStart <= 1'b0;
      diagStart <= 1'b0;
      scanStart <= 1'b0;
      gpoReset <= 1'b1;
    end else begin
      state <= state_q;
      restoreStart <= (state_q == tcpsm_pkg::StBoot) && !bootPhase_q; // RULE1
      diagStart <= (state_q == tcpsm_pkg::StBoot) && bootPhase_q; // RULE1
      scanStart <= startScan;
      ctl.scanRun <= scanBusy_q | startScan;
      ctl.scanAll <= (state_q == tcpsm_pkg::StActive) ||
        (state_q == tcpsm_pkg::StLookTouch); // RULE2 RULE3
      ctl.scanProxOnly <= (state_q == tcpsm_pkg::StLookProx); // RULE4
      ctl.lowPower <= lowPower_q; // RULE17
      ctl.outEnable <= (state_q == tcpsm_pkg::StActive); // RULE2
      ctl.hostIrqEnable <= (state_q == tcpsm_pkg::StActive); // RULE2 RULE6
      ctl.gpoEnable <= (state_q == tcpsm_pkg::StActive) ||
        (state_q == tcpsm_pkg::StLookTouch); // RULE3 RULE4
      ctl.nackAddr <= waking_q || state_q == tcpsm_pkg::StBoot; // RULE23
      gpoReset <= (state_q == tcpsm_pkg::StDeepSleep) ||
        (state_q == tcpsm_pkg::StBoot); // RULE5
    end
  end

  sequence s_bootOk;
    state_q == tcpsm_pkg::StBoot && bootPhase_q && diagDone && !cfgCorrupt;
  endsequence

  a_boot_to_active: assert property (@(posedge clk) disable iff (anyReset)
    s_bootOk ##0 !hostCfgWrite |=> state_q == tcpsm_pkg::StActive) // RULE24
    else $error("boot did not reach active");
  a_corrupt_to_cfg: assert property (@(posedge clk) disable iff (anyReset)
    state_q == tcpsm_pkg::StBoot && bootPhase_q && diagDone && cfgCorrupt
    |=> state_q == tcpsm_pkg::StConfig) // RULE9
    else $error("corrupt config not caught");
  a_config_stays: assert property (@(posedge clk) disable iff (anyReset)
    state_q == tcpsm_pkg::StConfig |=> state_q == tcpsm_pkg::StConfig ##1 !ctl.scanRun) // RULE6
    else $error("config state left");
  a_prox_entry: assert property (@(posedge clk) disable iff (anyReset)
    $rose(state_q == tcpsm_pkg::StLookProx) |-> proxAllowed) // RULE10
    else $error("prox entered while not allowed");
  a_active_hold: assert property (@(posedge clk) disable iff (anyReset)
    state_q == tcpsm_pkg::StActive && (touchSeen || buzzerBusy) && !hostCfgWrite
    && !hostSleepCmd |=> state_q == tcpsm_pkg::StActive) // RULE13
    else $error("active left while busy");
  a_sleep_cmd: assert property (@(posedge clk) disable iff (anyReset)
    hostSleepCmd && !hostCfgWrite && (state_q == tcpsm_pkg::StActive ||
    state_q == tcpsm_pkg::StLookTouch) |=> state_q == tcpsm_pkg::StDeepSleep
    ##1 gpoReset) // RULE7 RULE5
    else $error("sleep command ignored");
  a_cfg_write: assert property (@(posedge clk) disable iff (anyReset)
    hostCfgWrite && state_q == tcpsm_pkg::StActive |=> state_q == tcpsm_pkg::StConfig) // RULE8
    else $error("config write ignored");
  a_lp_skip: assert property (@(posedge clk) disable iff (anyReset)
    busActivity || sclLow |=> !lowPower_q) // RULE18
    else $error("low power during bus activity");
  a_prox_no_out: assert property (@(posedge clk) disable iff (anyReset)
    state_q == tcpsm_pkg::StLookProx [*2] |-> !ctl.outEnable && !ctl.gpoEnable) // RULE4
    else $error("outputs driven in prox");
  a_touch_wake: assert property (@(posedge clk) disable iff (anyReset)
    state_q == tcpsm_pkg::StLookTouch && touchSeen && !hostCfgWrite && !hostSleepCmd
    |=> state_q == tcpsm_pkg::StActive ##2 !ctl.nackAddr) // RULE12 RULE23
    else $error("touch did not wake");
endmodule
`default_nettype wire

/* File: dv/tcpsm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tcpsm_host_model (
  input wire logic clk,
  input wire logic nackAddr,
  output logic sleepCmd,
  output logic wakeCmd,
  output logic cfgWrite,
  output logic busActivity,
  output logic sclLow,
  output logic addrMatch
);
  // Idle bus with both lines released between transfers
  initial begin
    {cfgWrite, wakeCmd, sleepCmd} = 3'h0;
    busActivity = 1'h0;
    sclLow = 1'h0;
    addrMatch = 1'h0;
  end

  // One-cycle command: bit 2 config write, bit 1 wake, bit 0 sleep
  task send(input logic [2:0] sel);
    @(posedge clk);
    #1 {cfgWrite, wakeCmd, sleepCmd} = sel;
    @(posedge clk);
    #1 {cfgWrite, wakeCmd, sleepCmd} = 3'h0;
  endtask

  task hold_bus(input logic busy);
    @(posedge clk);
    #1 busActivity = busy;
  endtask

  task hold_scl(input logic low);
    @(posedge clk);
    #1 sclLow = low;
  endtask

  // Retries the address until acknowledged, bounded by maxTries
  task talk(input int maxTries, output logic acked);
    int t;
    acked = 1'h0;
    t = 0;
    busActivity = 1'h1;
    while (!acked && t < maxTries) begin
      @(posedge clk);
      #1 addrMatch = 1'h1;
      @(posedge clk);
      #1 addrMatch = 1'h0;
      repeat (3) @(posedge clk);
      #1 acked = (nackAddr === 1'h0);
      t++;
      if (!acked) repeat (10) @(posedge clk);
    end
    #1 busActivity = 1'h0;
  endtask
endmodule

`default_nettype wire

/* File: dv/test_touch_controller_power_state_manager.sv */
`timescale 1ns/1ps
`default_nettype none

module test_touch_controller_power_state_manager;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic swRst;
  tcpsm_pkg::tcpsm_cfg_s cfgIn;
  logic restoreDone;
  logic cfgCorrupt;
  logic diagDone;
  logic [7:0] diagFail;
  logic scanDone = 1'h0;
  logic touchSeen;
  logic proxSeen;
  logic buzzerBusy;
  wire sleepCmd, wakeCmd, cfgWrite, busAct, sclLow, addrMatch;
  tcpsm_pkg::tcpsm_state_e state;
  tcpsm_pkg::tcpsm_ctl_s ctl;
  logic restoreStart, diagStart, scanStart, gpoReset, sensorAutoReset;
  logic [7:0] faultPulse;
  logic [31:0] autoResetSec;
  logic acked;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int scanCount = 0;
  int gap = 0;
  int lastGap = 0;
  int scanWait = 0;
  int fpLen = 0;
  int arCount = 0;
  int n;

  tcpsm_top #(.SECOND_CYC(100), .ACTIVE_REFRESH_CYC(50), .SLOW_STEP_CYC(20),
    .FAULT_PULSE_CYC(10)) uut (.clk(clk), .rst(rst), .softwareResetCommand(swRst),
    .cfgIn(cfgIn), .restoreDone(restoreDone), .cfgCorrupt(cfgCorrupt), .diagDone(diagDone),
    .diagFail(diagFail), .scanDone(scanDone), .touchSeen(touchSeen), .proxSeen(proxSeen),
    .buzzerBusy(buzzerBusy), .hostSleepCmd(sleepCmd), .hostWakeCmd(wakeCmd),
    .hostCfgWrite(cfgWrite), .busActivity(busAct), .sclLow(sclLow), .addrMatch(addrMatch),
    .state(state), .ctl(ctl), .restoreStart(restoreStart), .diagStart(diagStart),
    .scanStart(scanStart), .gpoReset(gpoReset), .faultPulse(faultPulse),
    .sensorAutoReset(sensorAutoReset), .autoResetSec(autoResetSec));

  tcpsm_host_model host (.clk(clk), .nackAddr(ctl.nackAddr), .sleepCmd(sleepCmd),
    .wakeCmd(wakeCmd), .cfgWrite(cfgWrite), .busActivity(busAct), .sclLow(sclLow),
    .addrMatch(addrMatch));

  always #2 clk = ~clk;

  // Scan engine stand-in: five cycles per scan, plus gap and pulse counters
  always @(posedge clk) begin
    #1 scanDone = 1'h0;
    gap++;
    if (scanStart === 1'h1) begin
      scanWait = 5;
      scanCount++;
      lastGap = gap;
      gap = 0;
    end else if (scanWait > 0) begin
      scanWait--;
      if (scanWait == 0) scanDone = 1'h1;
    end
    if (faultPulse[2] === 1'h1) fpLen++;
    if (sensorAutoReset === 1'h1) arCount++;
  end

  // Full run needs about 1800 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      finish_test();
    end
  end

  task finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s exp %b got %b", name, exp, got);
    end
  endtask

  task chk_vec(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s exp %h got %h", name, exp, got);
    end
  endtask

  task chk_range(input string name, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("wrong value %s exp %0d..%0d got %0d", name, lo, hi, got);
    end
  endtask

  // Waits a bounded time for the state, then compares it
  task wait_st(input tcpsm_pkg::tcpsm_state_e e, input int max);
    n = 0;
    while (state !== e && n < max) begin
      @(posedge clk);
      #1 n++;
    end
    total_checks++;
    if (state !== e) begin
      err_count++;
      $display("wrong value state exp %s got %s", e.name(), state.name());
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task after_scan();
    int k;
    k = 0;
    // Sampled on the edge itself, before the stand-in clears the strobe
    do begin
      @(posedge clk);
      k++;
    end while (scanDone !== 1'h1 && k < 200);
    chk_bit("scanDone", 1'h1, scanDone);
    tick(4);
  endtask

  task boot(input tcpsm_pkg::tcpsm_cfg_s c, input logic bad, input logic [7:0] fail);
    int k;
    cfgIn = c;
    scanCount = 0;
    k = 0;
    while (restoreStart !== 1'h1 && k < 50) begin
      @(posedge clk);
      #1 k++;
    end
    chk_bit("restoreStart", 1'h1, restoreStart);
    restoreDone = 1'h1;
    tick(1);
    restoreDone = 1'h0;
    k = 0;
    while (diagStart !== 1'h1 && k < 50) begin
      @(posedge clk);
      #1 k++;
    end
    chk_bit("diagStart", 1'h1, diagStart);
    chk_range("scanCount", 0, 0, scanCount);
    {cfgCorrupt, diagFail, diagDone} = {bad, fail, 1'h1};
    tick(1);
    {cfgCorrupt, diagFail, diagDone} = '0;
    tick(3);
    chk_vec("faultPulse", {24'h000000, fail}, {24'h000000, faultPulse});
  endtask

  task soft_reset();
    swRst = 1'h1;
    tick(2);
    wait_st(tcpsm_pkg::StBoot, 1);
    swRst = 1'h0;
  endtask

  initial begin
    {swRst, restoreDone, cfgCorrupt, diagDone} = 4'h0;
    {touchSeen, proxSeen, buzzerBusy} = 3'h0;
    cfgIn = '0;
    diagFail = 8'h00;
    tick(19);
    wait_st(tcpsm_pkg::StBoot, 1);
    chk_bit("gpoReset", 1'h1, gpoReset);
    chk_vec("autoResetSec", 32'h5, autoResetSec);
    tick(1);
    rst = 1'h0;
    boot('{1'h1, 1'h0, 1'h0, 8'h02, 8'h03}, 1'h0, 8'h04);
    wait_st(tcpsm_pkg::StActive, 20);
    chk_bit("outEnable", 1'h1, ctl.outEnable);
    chk_bit("hostIrqEnable", 1'h1, ctl.hostIrqEnable);
    after_scan();
    chk_bit("lowPower", 1'h1, ctl.lowPower);
    after_scan();
    chk_range("activeGap", 50, 52, lastGap);
    host.hold_bus(1'h1);
    after_scan();
    chk_bit("lowPower", 1'h0, ctl.lowPower);
    host.hold_bus(1'h0);
    host.hold_scl(1'h1);
    after_scan();
    chk_bit("lowPower", 1'h0, ctl.lowPower);
    host.hold_scl(1'h0);
    arCount = 0;
    touchSeen = 1'h1;
    tick(540);
    wait_st(tcpsm_pkg::StActive, 1);
    chk_range("autoResets", 1, 1, arCount);
    {buzzerBusy, touchSeen} = 2'h2;
    tick(300);
    wait_st(tcpsm_pkg::StActive, 1);
    buzzerBusy = 1'h0;
    wait_st(tcpsm_pkg::StLookTouch, 210);
    wait_st(tcpsm_pkg::StLookProx, 210);
    chk_range("touchFree", 198, 204, n);
    chk_bit("scanProxOnly", 1'h1, ctl.scanProxOnly);
    chk_bit("outEnable", 1'h0, ctl.outEnable);
    chk_bit("gpoEnable", 1'h0, ctl.gpoEnable);
    proxSeen = 1'h1;
    wait_st(tcpsm_pkg::StLookTouch, 20);
    after_scan();
    after_scan();
    chk_range("slowGap", 60, 62, lastGap);
    chk_bit("scanAll", 1'h1, ctl.scanAll);
    chk_bit("gpoEnable", 1'h1, ctl.gpoEnable);
    touchSeen = 1'h1;
    wait_st(tcpsm_pkg::StActive, 100);
    {touchSeen, proxSeen} = 2'h0;
    host.send(3'h1);
    wait_st(tcpsm_pkg::StDeepSleep, 10);
    chk_bit("scanRun", 1'h0, ctl.scanRun);
    chk_bit("gpoReset", 1'h1, gpoReset);
    host.talk(1, acked);
    chk_bit("acked", 1'h0, acked);
    host.send(3'h2);
    wait_st(tcpsm_pkg::StActive, 10);
    host.talk(20, acked);
    chk_bit("acked", 1'h1, acked);
    host.send(3'h4);
    wait_st(tcpsm_pkg::StConfig, 10);
    chk_bit("scanRun", 1'h0, ctl.scanRun);
    chk_bit("hostIrqEnable", 1'h0, ctl.hostIrqEnable);
    host.send(3'h2);
    tick(5);
    wait_st(tcpsm_pkg::StConfig, 1);
    soft_reset();
    boot('{1'h1, 1'h0, 1'h0, 8'h02, 8'h03}, 1'h1, 8'h00);
    wait_st(tcpsm_pkg::StConfig, 20);
    soft_reset();
    boot('{1'h1, 1'h1, 1'h1, 8'h01, 8'h01}, 1'h0, 8'h00);
    wait_st(tcpsm_pkg::StActive, 20);
    chk_vec("autoResetSec", 32'h14, autoResetSec);
    wait_st(tcpsm_pkg::StLookTouch, 120);
    tick(300);
    wait_st(tcpsm_pkg::StLookTouch, 1);
    chk_range("faultLen", 10, 10, fpLen);
    finish_test();
  end
endmodule

`default_nettype wire
